// file: hdl/dpt_pkg.sv
// Contract
// - Filter changes level after four equal samples.
// - Async mode lets input A event stop outputs directly, except in modes eight and nine.
// - Config zero: no filter, no async path.
// - Polarity zero falling/low, one rising/high.
// - Action one adds counter capture to fault.
// - First event is trigger for input A.
// - Second event is trigger for input B.
// - Input A/B interrupts gated by bits 2/3.
// - Cycle-end interrupt gated by enable bit 0.
// - Input B flag set by event, write-one clears.
// - Input A flag set by event, write-one clears.
// - Cycle-end flag set each cycle, write-one clears.
// - Output B toggle sets sticky activity bit.
// - Output A toggle sets sticky activity bit.
// - Command ready rises once command is carried.
// - Command strobes or auto-update write drop ready.
// - Enable ready rises once enable is carried.
// - Enable write, disable strobe, debug break drop ready.
// - Modes one to three stop output, opposite cycle.
// - Modes four to seven stop all outputs.
// - Modes eight to ten edge/level stop output.
// - Commands accepted only while command ready.
`default_nettype none
package dpt_pkg;
  localparam logic [7:0] IDX_ENABLE     = 8'h00;
  localparam logic [7:0] IDX_UPDATE     = 8'h02;
  localparam logic [7:0] IDX_STROBE     = 8'h04;
  localparam logic [7:0] IDX_EVENT_A    = 8'h08;
  localparam logic [7:0] IDX_EVENT_B    = 8'h09;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h0c;
  localparam logic [7:0] IDX_INT_FLAGS  = 8'h0d;
  localparam logic [7:0] IDX_STATUS     = 8'h0e;
  localparam logic [7:0] IDX_INPUT_A    = 8'h10;
  localparam logic [7:0] IDX_DEBUG      = 8'h1e;
  localparam logic [7:0] IDX_CMPB_CLRH  = 8'h27;
  localparam logic [7:0] REG_RESET      = 8'h00;

  localparam int BIT_ENABLE      = 0;
  localparam int BIT_AUTO_UPDATE = 1;
  localparam int BIT_RUN_HALTED  = 0;
  localparam int BIT_SYNC_EOC    = 0;
  localparam int BIT_SYNC        = 1;
  localparam int BIT_RESTART     = 2;
  localparam int BIT_SCAP_A      = 3;
  localparam int BIT_SCAP_B      = 4;
  localparam int BIT_DIS_EOC     = 7;
  localparam int BIT_TRIG_EN     = 0;
  localparam int BIT_ACTION      = 2;
  localparam int BIT_EDGE        = 4;
  localparam int CFG_LSB         = 6;
  localparam int BIT_FLAG_CYCLE  = 0;
  localparam int BIT_FLAG_A      = 2;
  localparam int BIT_FLAG_B      = 3;
  localparam int BIT_EN_READY    = 0;
  localparam int BIT_CMD_READY   = 1;
  localparam int BIT_ACT_A       = 6;
  localparam int BIT_ACT_B       = 7;

  localparam logic [7:0] INT_MASK    = 8'h0d;
  localparam logic [7:0] STROBE_MASK = 8'h9f;
  localparam logic [7:0] EVENT_MASK  = 8'hd5;
  localparam logic [7:0] MODE_MASK   = 8'h0f;

  localparam logic [1:0] CFG_NEITHER = 2'h0;
  localparam logic [1:0] CFG_FILTER  = 2'h1;
  localparam logic [1:0] CFG_ASYNC   = 2'h2;

  localparam logic [3:0] MODE_NONE         = 4'h0;
  localparam logic [3:0] MODE_JUMP_OPP     = 4'h1;
  localparam logic [3:0] MODE_RUN_OPP      = 4'h2;
  localparam logic [3:0] MODE_RUN_OPP_LVL  = 4'h3;
  localparam logic [3:0] MODE_ALL_PERIOD   = 4'h4;
  localparam logic [3:0] MODE_ALL_DEADTIME = 4'h5;
  localparam logic [3:0] MODE_ALL_JUMP     = 4'h6;
  localparam logic [3:0] MODE_ALL_SW       = 4'h7;
  localparam logic [3:0] MODE_EDGE_JUMP    = 4'h8;
  localparam logic [3:0] MODE_EDGE_PERIOD  = 4'h9;
  localparam logic [3:0] MODE_LEVEL_PERIOD = 4'ha;

  localparam int         FILTER_SAMPLES = 4;
  localparam logic [1:0] SYNC_CYCLES    = 2'h2;
endpackage : dpt_pkg
`default_nettype wire

// file: hdl/dpt_event_in.sv
`default_nettype none
module dpt_event_in
  import dpt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       event_raw,
  input  wire logic [1:0] cfg,
  input  wire logic       rise_high,
  output logic            fault_level,
  output logic            fault_edge,
  output logic            async_level
);
  logic                        sample_r;
  logic [FILTER_SAMPLES-2:0]   hist_r;
  logic                        filt_r;
  logic                        prev_r;
  logic                        qual;
  logic                        valid_cfg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_r <= 1'b0;
      hist_r   <= '0;
    end else begin
      sample_r <= event_raw;
      hist_r   <= {hist_r[FILTER_SAMPLES-3:0], sample_r};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_r <= 1'b0;
    end else if (&{hist_r, sample_r} || ~|{hist_r, sample_r}) begin
      filt_r <= sample_r;
    end
  end

  // Reserved code gives no action at all
  assign valid_cfg   = (cfg == CFG_NEITHER) || (cfg == CFG_FILTER) || (cfg == CFG_ASYNC);
  assign qual        = (cfg == CFG_FILTER) ? filt_r : sample_r;
  assign fault_level = valid_cfg && (qual == rise_high);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= fault_level;
    end
  end

  assign fault_edge  = fault_level && !prev_r;
  // Bypasses the sampler, so glitches on the event net reach the outputs
  assign async_level = (cfg == CFG_ASYNC) && (event_raw == rise_high);
endmodule // dpt_event_in
`default_nettype wire

// file: hdl/dpt_sync_delay.sv
`default_nettype none
module dpt_sync_delay
  import dpt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic hold,
  output logic      ready,
  output logic      done
);
  logic [1:0] cnt_r;

  // Comes out of reset pending, so ready rises a few cycles after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= SYNC_CYCLES;
    end else if (start || hold) begin
      cnt_r <= SYNC_CYCLES;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  assign ready = (cnt_r == 2'h0);
  assign done  = (cnt_r == 2'h1) && !start && !hold;
endmodule // dpt_sync_delay
`default_nettype wire

// file: hdl/dpt_timer_events.sv
// Our own choice: the AHB-Lite interface to the registers.
`default_nettype none
module dpt_timer_events
  import dpt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        event_a,
  input  wire logic        event_b,
  input  wire logic        waveform_output_a,
  input  wire logic        waveform_output_b,
  input  wire logic        cycle_end,
  input  wire logic        debug_halt,
  output logic             gated_output_a,
  output logic             gated_output_b,
  output logic             capture_a_req,
  output logic             capture_b_req,
  output logic             irq_input_a,
  output logic             irq_input_b,
  output logic             irq_cycle_end,
  output logic             timer_enable,
  output logic             sync_now_pulse,
  output logic             sync_at_cycle_end_pulse,
  output logic             restart_pulse,
  output logic             resp_jump_opposite,
  output logic             resp_run_opposite,
  output logic             resp_jump_next,
  output logic             resp_dead_time,
  output logic             resp_keep_period,
  output logic             resp_hold
);
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [1:0] halt_sync_r;

  logic       dph_write_r;
  logic       dph_read_r;
  logic [7:0] dph_index_r;
  logic       wr;
  logic [7:0] wdata;

  logic [7:0] event_ctrl_a_r;
  logic [7:0] event_ctrl_b_r;
  logic [7:0] int_enable_r;
  logic [7:0] input_mode_r;
  logic       auto_update_r;
  logic       run_halted_r;
  logic       enable_req_r;
  logic       enable_timer_r;
  logic       dis_pend_r;
  logic       flag_a_r;
  logic       flag_b_r;
  logic       flag_cycle_r;
  logic       act_a_r;
  logic       act_b_r;
  logic       wave_a_r;
  logic       wave_b_r;
  logic [4:0] cmd_pend_r;
  logic [4:0] cmd_exec_r;
  logic       cap_a_r;
  logic       cap_b_r;
  logic       hold_r;

  logic [1:0] ev_raw;
  logic [7:0] ev_ctrl [2];
  logic [1:0] ev_level;
  logic [1:0] ev_edge;
  logic [1:0] ev_async;
  logic [1:0] trig_level;
  logic [1:0] trig_edge;

  logic       cmd_ready;
  logic       cmd_done;
  logic       cmd_start;
  logic [4:0] cmd_new;
  logic       en_ready;
  logic       en_done;
  logic       en_start;
  logic       en_hold;
  logic       fault_a;
  logic       stop_one;
  logic       stop_all;
  logic       is_hold_mode;

  function automatic logic is_reg(input logic [7:0] index, input logic [7:0] target);
    is_reg = (index == target);
  endfunction

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halt_sync_r <= 2'h0;
    end else begin
      halt_sync_r <= {halt_sync_r[0], debug_halt};
    end
  end

  // Zero-wait slave: address phase latched, effects in the data phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dph_write_r <= 1'b0;
      dph_read_r  <= 1'b0;
      dph_index_r <= 8'h00;
    end else if (hready) begin
      dph_write_r <= hsel && htrans[1] && hwrite;
      dph_read_r  <= hsel && htrans[1] && !hwrite;
      dph_index_r <= haddr[9:2];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr        = dph_write_r;
  assign wdata     = hwdata[7:0];

  always_comb begin
    hrdata = 32'h0000_0000;
    if (dph_read_r) begin
      case (dph_index_r)
        IDX_ENABLE:     hrdata[BIT_ENABLE] = enable_req_r;
        IDX_UPDATE:     hrdata[BIT_AUTO_UPDATE] = auto_update_r;
        IDX_EVENT_A:    hrdata[7:0] = event_ctrl_a_r;
        IDX_EVENT_B:    hrdata[7:0] = event_ctrl_b_r;
        IDX_INT_ENABLE: hrdata[7:0] = int_enable_r;
        IDX_INT_FLAGS: begin
          hrdata[BIT_FLAG_A]     = flag_a_r;
          hrdata[BIT_FLAG_B]     = flag_b_r;
          hrdata[BIT_FLAG_CYCLE] = flag_cycle_r;
        end
        IDX_STATUS: begin
          hrdata[BIT_ACT_A]     = act_a_r;
          hrdata[BIT_ACT_B]     = act_b_r;
          hrdata[BIT_CMD_READY] = cmd_ready;
          hrdata[BIT_EN_READY]  = en_ready;
        end
        IDX_INPUT_A:    hrdata[7:0] = input_mode_r;
        IDX_DEBUG:      hrdata[BIT_RUN_HALTED] = run_halted_r;
        default:        hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_ctrl_a_r <= REG_RESET;
      event_ctrl_b_r <= REG_RESET;
      int_enable_r   <= REG_RESET;
      input_mode_r   <= REG_RESET;
      auto_update_r  <= 1'b0;
      run_halted_r   <= 1'b0;
    end else if (wr) begin
      if (is_reg(dph_index_r, IDX_EVENT_A)) event_ctrl_a_r <= wdata & EVENT_MASK;
      if (is_reg(dph_index_r, IDX_EVENT_B)) event_ctrl_b_r <= wdata & EVENT_MASK;
      if (is_reg(dph_index_r, IDX_INT_ENABLE)) int_enable_r <= wdata & INT_MASK;
      if (is_reg(dph_index_r, IDX_INPUT_A)) input_mode_r <= wdata & MODE_MASK;
      if (is_reg(dph_index_r, IDX_UPDATE)) auto_update_r <= wdata[BIT_AUTO_UPDATE];
      if (is_reg(dph_index_r, IDX_DEBUG)) run_halted_r <= wdata[BIT_RUN_HALTED];
    end
  end

  assign ev_raw     = {event_b, event_a};
  assign ev_ctrl[0] = event_ctrl_a_r;
  assign ev_ctrl[1] = event_ctrl_b_r;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_event
      dpt_event_in u_event (
        .clk         (clk_sys),
        .rst_n       (rst_n),
        .event_raw   (ev_raw[i]),
        .cfg         (ev_ctrl[i][CFG_LSB+1:CFG_LSB]),
        .rise_high   (ev_ctrl[i][BIT_EDGE]),
        .fault_level (ev_level[i]),
        .fault_edge  (ev_edge[i]),
        .async_level (ev_async[i])
      );
      assign trig_level[i] = ev_ctrl[i][BIT_TRIG_EN] && (ev_level[i] || ev_async[i]);
      assign trig_edge[i]  = ev_ctrl[i][BIT_TRIG_EN] && ev_edge[i];
    end
  endgenerate

  // Command path: strobes taken only while no command is in flight
  assign cmd_new[BIT_SYNC_EOC] = wr && is_reg(dph_index_r, IDX_STROBE) && wdata[BIT_SYNC_EOC]
                                 || wr && is_reg(dph_index_r, IDX_CMPB_CLRH) && auto_update_r;
  assign cmd_new[BIT_SYNC]     = wr && is_reg(dph_index_r, IDX_STROBE) && wdata[BIT_SYNC];
  assign cmd_new[BIT_RESTART]  = wr && is_reg(dph_index_r, IDX_STROBE) && wdata[BIT_RESTART];
  assign cmd_new[BIT_SCAP_A]   = wr && is_reg(dph_index_r, IDX_STROBE) && wdata[BIT_SCAP_A];
  assign cmd_new[BIT_SCAP_B]   = wr && is_reg(dph_index_r, IDX_STROBE) && wdata[BIT_SCAP_B];
  assign cmd_start             = cmd_ready && (|cmd_new);

  dpt_sync_delay u_cmd_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .start (cmd_start),
    .hold  (1'b0),
    .ready (cmd_ready),
    .done  (cmd_done)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_pend_r <= 5'h00;
      cmd_exec_r <= 5'h00;
    end else begin
      if (cmd_start) begin
        cmd_pend_r <= cmd_new;
      end else if (cmd_done) begin
        cmd_pend_r <= 5'h00;
      end
      cmd_exec_r <= cmd_done ? cmd_pend_r : 5'h00;
    end
  end

  assign sync_at_cycle_end_pulse = cmd_exec_r[BIT_SYNC_EOC];
  assign sync_now_pulse          = cmd_exec_r[BIT_SYNC];
  assign restart_pulse           = cmd_exec_r[BIT_RESTART];

  // Enable path; a write during synchronisation is dropped, not queued
  assign en_start = en_ready && wr && is_reg(dph_index_r, IDX_ENABLE);
  assign en_hold  = dis_pend_r || (halt_sync_r[1] && !run_halted_r);

  dpt_sync_delay u_en_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .start (en_start),
    .hold  (en_hold),
    .ready (en_ready),
    .done  (en_done)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_req_r <= 1'b0;
      dis_pend_r   <= 1'b0;
    end else begin
      if (en_start) begin
        enable_req_r <= wdata[BIT_ENABLE];
      end else if (dis_pend_r && cycle_end) begin
        enable_req_r <= 1'b0;
      end
      if (dis_pend_r && cycle_end) begin
        dis_pend_r <= 1'b0;
      end else if (en_ready && wr && is_reg(dph_index_r, IDX_STROBE) && wdata[BIT_DIS_EOC]) begin
        dis_pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_timer_r <= 1'b0;
    end else if (en_done) begin
      enable_timer_r <= enable_req_r;
    end
  end
  assign timer_enable = enable_timer_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_a_r <= 1'b0;
      cap_b_r <= 1'b0;
    end else begin
      cap_a_r <= trig_edge[0] && event_ctrl_a_r[BIT_ACTION] || cmd_exec_r[BIT_SCAP_A];
      cap_b_r <= trig_edge[1] && event_ctrl_b_r[BIT_ACTION] || cmd_exec_r[BIT_SCAP_B];
    end
  end
  assign capture_a_req = cap_a_r;
  assign capture_b_req = cap_b_r;

  // Flags: a hardware set in the same cycle as a clear wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_a_r     <= 1'b0;
      flag_b_r     <= 1'b0;
      flag_cycle_r <= 1'b0;
    end else begin
      if (trig_edge[0] || cmd_exec_r[BIT_SCAP_A]) begin
        flag_a_r <= 1'b1;
      end else if (wr && is_reg(dph_index_r, IDX_INT_FLAGS) && wdata[BIT_FLAG_A]) begin
        flag_a_r <= 1'b0;
      end
      if (trig_edge[1] || cmd_exec_r[BIT_SCAP_B]) begin
        flag_b_r <= 1'b1;
      end else if (wr && is_reg(dph_index_r, IDX_INT_FLAGS) && wdata[BIT_FLAG_B]) begin
        flag_b_r <= 1'b0;
      end
      if (cycle_end) begin
        flag_cycle_r <= 1'b1;
      end else if (wr && is_reg(dph_index_r, IDX_INT_FLAGS) && wdata[BIT_FLAG_CYCLE]) begin
        flag_cycle_r <= 1'b0;
      end
    end
  end

  assign irq_input_a   = flag_a_r && int_enable_r[BIT_FLAG_A];
  assign irq_input_b   = flag_b_r && int_enable_r[BIT_FLAG_B];
  assign irq_cycle_end = flag_cycle_r && int_enable_r[BIT_FLAG_CYCLE];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
      act_a_r  <= 1'b0;
      act_b_r  <= 1'b0;
    end else begin
      wave_a_r <= waveform_output_a;
      wave_b_r <= waveform_output_b;
      if (waveform_output_a != wave_a_r) begin
        act_a_r <= 1'b1;
      end else if (wr && is_reg(dph_index_r, IDX_STATUS) && wdata[BIT_ACT_A]) begin
        act_a_r <= 1'b0;
      end
      if (waveform_output_b != wave_b_r) begin
        act_b_r <= 1'b1;
      end else if (wr && is_reg(dph_index_r, IDX_STATUS) && wdata[BIT_ACT_B]) begin
        act_b_r <= 1'b0;
      end
    end
  end

  // Input A response; the hold outlives the fault until the engine's next cycle end, or in mode 7 until a restart command
  assign fault_a      = trig_level[0];
  assign is_hold_mode = (input_mode_r[3:0] == MODE_JUMP_OPP) || (input_mode_r[3:0] == MODE_RUN_OPP)
                        || (input_mode_r[3:0] == MODE_ALL_JUMP) || (input_mode_r[3:0] == MODE_ALL_SW)
                        || (input_mode_r[3:0] == MODE_EDGE_JUMP) || (input_mode_r[3:0] == MODE_EDGE_PERIOD);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b0;
    end else if (trig_edge[0] && is_hold_mode) begin
      hold_r <= 1'b1;
    end else if (input_mode_r[3:0] == MODE_ALL_SW) begin
      if (cmd_exec_r[BIT_RESTART]) hold_r <= 1'b0;
    end else if (!is_hold_mode || (cycle_end && !fault_a)) begin
      hold_r <= 1'b0;
    end
  end

  always_comb begin
    stop_one           = 1'b0;
    stop_all           = 1'b0;
    resp_jump_opposite = 1'b0;
    resp_run_opposite  = 1'b0;
    resp_jump_next     = 1'b0;
    resp_dead_time     = 1'b0;
    resp_keep_period   = 1'b0;
    case (input_mode_r[3:0])
      MODE_JUMP_OPP: begin
        stop_one           = hold_r || fault_a;
        resp_jump_opposite = trig_edge[0];
      end
      MODE_RUN_OPP: begin
        stop_one          = hold_r || fault_a;
        resp_run_opposite = hold_r;
      end
      MODE_RUN_OPP_LVL: begin
        stop_one          = fault_a;
        resp_run_opposite = fault_a;
      end
      MODE_ALL_PERIOD: begin
        stop_all         = fault_a;
        resp_keep_period = fault_a;
      end
      MODE_ALL_DEADTIME: begin
        stop_all       = fault_a;
        resp_dead_time = fault_a;
      end
      MODE_ALL_JUMP: begin
        stop_all       = hold_r || fault_a;
        resp_jump_next = trig_edge[0];
      end
      MODE_ALL_SW: begin
        stop_all = hold_r || fault_a;
      end
      MODE_EDGE_JUMP: begin
        stop_one       = hold_r;
        resp_jump_next = trig_edge[0];
      end
      MODE_EDGE_PERIOD: begin
        stop_one         = hold_r;
        resp_keep_period = hold_r;
      end
      MODE_LEVEL_PERIOD: begin
        stop_one         = fault_a;
        resp_keep_period = fault_a;
      end
      default: begin
        stop_one = 1'b0;
      end
    endcase
  end

  assign resp_hold = hold_r;
  // Combinational gate so the async path can cut the outputs within the cycle
  assign gated_output_a = waveform_output_a && !(stop_one || stop_all);
  assign gated_output_b = waveform_output_b && !stop_all;
endmodule // dpt_timer_events
`default_nettype wire

// file: test/dpt_timer_events_chk.sv
`default_nettype none
module dpt_timer_events_chk (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       cycle_end,
  input wire logic       waveform_output_a,
  input wire logic       waveform_output_b,
  input wire logic       gated_output_a,
  input wire logic       gated_output_b,
  input wire logic       capture_a_req,
  input wire logic       irq_input_a,
  input wire logic       irq_cycle_end,
  input wire logic       sync_now_pulse,
  input wire logic       restart_pulse,
  input wire logic       resp_jump_next,
  input wire logic       resp_hold,
  input wire logic       resp_dead_time
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Marks a write data phase, the only time a flag may be cleared
  logic wr_dp_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_dp_r <= 1'b0;
    end else begin
      wr_dp_r <= hsel && hready && htrans[1] && hwrite;
    end
  end
  chk_cap_a_pulse: assert property (capture_a_req |=> !capture_a_req)
    else $error("capture A pulse longer than one cycle");
  chk_cmd_spacing: assert property ((sync_now_pulse || restart_pulse) |=> !(sync_now_pulse || restart_pulse) [*2])
    else $error("commands executed without sync gap");
  chk_flag_a_clear: assert property ($fell(irq_input_a) |-> $past(wr_dp_r))
    else $error("input A flag cleared without write");
  chk_cycle_clear: assert property ($fell(irq_cycle_end) |-> $past(wr_dp_r))
    else $error("cycle flag cleared without write");
  chk_cycle_set: assert property ($rose(irq_cycle_end) |-> $past(cycle_end) || $past(wr_dp_r))
    else $error("cycle interrupt without cycle end");
  chk_gate_a_stop: assert property ($rose(resp_hold) |-> !gated_output_a)
    else $error("output A not stopped by hold");
  chk_gate_b_stop: assert property (resp_dead_time |-> !gated_output_b)
    else $error("output B not stopped in dead-time mode");
  chk_jump_pulse: assert property (resp_jump_next |=> !resp_jump_next)
    else $error("jump request longer than one cycle");
  cov_capture: cover property (capture_a_req);
  cov_sync: cover property (sync_now_pulse);
  cov_jump: cover property (resp_jump_next);
endmodule // dpt_timer_events_chk
bind dpt_timer_events dpt_timer_events_chk u_chk (.clk_sys, .reset_n, .hsel, .htrans, .hwrite, .hready, .cycle_end,
  .waveform_output_a, .waveform_output_b, .gated_output_a, .gated_output_b, .capture_a_req, .irq_input_a,
  .irq_cycle_end, .sync_now_pulse, .restart_pulse, .resp_jump_next, .resp_hold, .resp_dead_time);
`default_nettype wire

// file: test/dpt_event_net.sv
`default_nettype none
module dpt_event_net (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic req_a,
  input  wire logic req_b,
  output logic      event_a,
  output logic      event_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // One routing stage of latency; both lines idle low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      event_a <= 1'b0;
      event_b <= 1'b0;
    end else begin
      event_a <= req_a;
      event_b <= req_b;
    end
  end
endmodule // dpt_event_net
`default_nettype wire

// file: test/testbench.sv
`default_nettype none
module testbench;
  import dpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_a = 1'b0, req_b = 1'b0;
  logic        waveform_output_a = 1'b0, waveform_output_b = 1'b0, cycle_end = 1'b0, debug_halt = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_q;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, rdy_q, event_a, event_b, gated_output_a, gated_output_b, timer_enable;
  logic        irq_input_a, irq_input_b, irq_cycle_end, sync_now_pulse, restart_pulse;
  logic        sync_seen = 1'b0, rst_seen = 1'b0;
  logic [7:0]  modes [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h0b};
  logic [5:0]  stop_a = 6'b011110, stop_b = 6'b001100;
  int          err_total = 0, samples_checked = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
    if (sync_now_pulse) sync_seen <= 1'b1;
    if (restart_pulse) rst_seen <= 1'b1;
  end
  dpt_event_net u_net (.clk_sys, .reset_n, .req_a, .req_b, .event_a, .event_b);
  dpt_timer_events dut (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp(), .hrdata, .event_a, .event_b, .waveform_output_a, .waveform_output_b, .cycle_end,
    .debug_halt, .gated_output_a, .gated_output_b, .capture_a_req(), .capture_b_req(), .irq_input_a,
    .irq_input_b, .irq_cycle_end, .timer_enable, .sync_now_pulse, .sync_at_cycle_end_pulse(), .restart_pulse,
    .resp_jump_opposite(), .resp_run_opposite(), .resp_jump_next(), .resp_dead_time(), .resp_keep_period(),
    .resp_hold());
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for hready; a hang ends the run as a mismatch
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (rdy_q !== 1'b1 && n < 20);
    if (rdy_q !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = rd_q;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(i, 1'b1, d, q);
  endtask
  task automatic rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
    logic [31:0] q;
    bus(i, 1'b0, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    tick(6);
    rchk("status", IDX_STATUS, 8'h03);
    rchk("int_enable", IDX_INT_ENABLE, REG_RESET);
    rchk("flags", IDX_INT_FLAGS, REG_RESET);
    rchk("mode_a", IDX_INPUT_A, REG_RESET);
    rchk("unmapped", 8'h3f, 8'h00);
    wr(IDX_INT_ENABLE, 8'hff);
    rchk("int_enable", IDX_INT_ENABLE, INT_MASK);
    waveform_output_a <= 1'b1;
    waveform_output_b <= 1'b1;
    tick(2);
    rchk("status", IDX_STATUS, 8'hc3);
    wr(IDX_STATUS, 8'h43);
    rchk("status", IDX_STATUS, 8'h83);
    wr(IDX_STATUS, 8'h80);
    rchk("status", IDX_STATUS, 8'h03);
    // Filtered input B: a three-sample glitch must not pass
    wr(IDX_EVENT_B, 8'h55);
    req_b <= 1'b1;
    tick(3);
    req_b <= 1'b0;
    tick(8);
    rchk("flags", IDX_INT_FLAGS, 8'h00);
    req_b <= 1'b1;
    tick(8);
    chk("irq_b", 32'h1, {31'h0, irq_input_b});
    wr(IDX_INT_FLAGS, 8'h00);
    rchk("flags", IDX_INT_FLAGS, 8'h08);
    wr(IDX_INT_FLAGS, 8'h08);
    rchk("flags", IDX_INT_FLAGS, 8'h00);
    req_b <= 1'b0;
    cycle_end <= 1'b1;
    tick(1);
    cycle_end <= 1'b0;
    tick(1);
    chk("irq_cycle", 32'h1, {31'h0, irq_cycle_end});
    wr(IDX_EVENT_A, 8'h15);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_INPUT_A, modes[i]);
      req_a <= 1'b1;
      tick(4);
      chk("gated_a", {31'h0, ~stop_a[i]}, {31'h0, gated_output_a});
      chk("gated_b", {31'h0, ~stop_b[i]}, {31'h0, gated_output_b});
      req_a <= 1'b0;
      tick(4);
      cycle_end <= 1'b1;
      tick(1);
      cycle_end <= 1'b0;
      tick(3);
      chk("gated_a", 32'h1, {31'h0, gated_output_a});
    end
    chk("irq_a", 32'h1, {31'h0, irq_input_a});
    rchk("flags", IDX_INT_FLAGS, 8'h05);
    wr(IDX_INT_FLAGS, 8'h05);
    rchk("flags", IDX_INT_FLAGS, 8'h00);
    // Second strobe lands while the first is still crossing over
    wr(IDX_STROBE, 8'h02);
    wr(IDX_STROBE, 8'h04);
    tick(6);
    rchk("status", IDX_STATUS, 8'h03);
    chk("sync_seen", 32'h1, {31'h0, sync_seen});
    chk("restart_seen", 32'h0, {31'h0, rst_seen});
    wr(IDX_STROBE, 8'h08);
    rchk("status", IDX_STATUS, 8'h01);
    tick(6);
    rchk("flags", IDX_INT_FLAGS, 8'h04);
    wr(IDX_ENABLE, 8'h01);
    rchk("status", IDX_STATUS, 8'h02);
    tick(4);
    rchk("status", IDX_STATUS, 8'h03);
    chk("timer_enable", 32'h1, {31'h0, timer_enable});
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
